// >>> rtl/log_memory.sv
`timescale 1ns/100ps
module log_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial
  begin
    if (WIDTH < 1 || DEPTH < 2) $error("log_memory: bad size");
  end

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : log_memory

// >>> rtl/test_scheduling_sequencer.sv
`timescale 1ns/100ps
module test_scheduling_sequencer
  import test_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int DEPTH = LOG_DEPTH,
  parameter int AW = $clog2(LOG_DEPTH)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic cfg_defaults,
  input wire logic duration_wr,
  input wire logic [test_seq_pkg::SEC_W-1:0] duration_in,
  input wire logic [test_seq_pkg::SEC_W-1:0] interval_s,
  input wire logic [test_seq_pkg::SEC_W-1:0] log_interval_s,
  input wire logic continuous_test,
  input wire logic continuous_log,
  input wire logic simulated,
  input wire logic low_flow_off,
  input wire logic stop_when_clean,
  input wire logic confirm_en,
  input wire logic [test_seq_pkg::CNT_W-1:0] confirm_count,
  input wire logic [test_seq_pkg::CNT_W-1:0] ignore_count,
  input wire test_seq_pkg::format_e format,
  input wire logic [test_seq_pkg::NUM_CH-1:0] target_set,
  input wire logic [test_seq_pkg::NUM_CH-1:0][test_seq_pkg::CODE_W-1:0] target_code,
  input wire logic flow_pin,
  input wire logic particle_gt4,
  input wire logic [test_seq_pkg::NUM_CH-1:0][test_seq_pkg::CODE_W-1:0] result_code,
  input wire logic [AW-1:0] log_rd_addr,
  output logic testing,
  output logic waiting,
  output logic test_done,
  output logic test_valid,
  output logic flow_shown,
  output logic low_count_fault,
  output logic result_clean,
  output logic clean_alarm,
  output logic cfg_error,
  output logic [test_seq_pkg::NUM_W-1:0] test_number,
  output test_seq_pkg::format_e result_format,
  output logic [AW:0] log_count,
  output logic [AW-1:0] log_head,
  output logic [test_seq_pkg::REC_W-1:0] log_rd_data
);
  import test_seq_pkg::*;

  initial
  begin
    if (TICK_CYCLES < 1 || DEPTH < 2 || (2 ** AW) < DEPTH) $error("sequencer: bad parameters");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_TESTING, ST_WAITING} state_e;

  // flow level from the sensor pin
  logic flow_meta_r, flow_r;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      flow_meta_r <= 1'b0;
      flow_r <= 1'b0;
    end
    else
    begin
      flow_meta_r <= flow_pin;
      flow_r <= flow_meta_r;
    end
  end

  // one-second tick
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  always_comb
  begin
    tick_nxt = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick_nxt ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // per-channel target check in the selected format
  logic [NUM_CH-1:0] ch_met;
  logic [NUM_CH-1:0] fmt_mask;
  assign fmt_mask = FMT_MASK[format];
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    assign ch_met[i] = !target_set[i] || !fmt_mask[i] || (result_code[i] <= target_code[i]);
  end

  // sequencer state
  state_e state_r, state_nxt;
  logic [SEC_W-1:0] duration_r, duration_nxt, elapsed_r, elapsed_nxt;
  logic [SEC_W:0] log_acc_r, log_acc_nxt, period, acc_sum;
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt;
  logic [CNT_W-1:0] ignore_left_r, ignore_left_nxt, clean_run_r, clean_run_nxt;
  logic log_due_r, log_due_nxt, finish_ev, halt_x, valid_x, want_log;
  logic testing_nxt, waiting_nxt, done_nxt, valid_nxt, clean_nxt, fault_nxt, alarm_nxt, log_wr_nxt;
  logic testing_r, waiting_r, done_r, valid_r, clean_r, fault_r, alarm_r, log_wr_r, flow_ok;
  logic [NUM_W-1:0] number_r, number_nxt;
  format_e fmt_r, fmt_nxt;
  logic [NUM_CH*CODE_W-1:0] codes_r, codes_nxt;

  always_comb
  begin
    state_nxt = state_r;
    elapsed_nxt = elapsed_r;
    pcnt_nxt = pcnt_r;
    ignore_left_nxt = ignore_left_r;
    clean_run_nxt = clean_run_r;
    log_acc_nxt = log_acc_r;
    log_due_nxt = log_due_r;
    number_nxt = number_r;
    fmt_nxt = fmt_r;
    codes_nxt = codes_r;
    valid_nxt = valid_r;
    clean_nxt = clean_r;
    fault_nxt = fault_r;
    alarm_nxt = alarm_r;
    done_nxt = 1'b0;
    log_wr_nxt = 1'b0;
    finish_ev = 1'b0;
    halt_x = 1'b0;
    want_log = 1'b0;
    duration_nxt = duration_r;
    if (cfg_defaults)
    begin
      duration_nxt = DURATION_DEF_S;
    end
    else if (duration_wr)
    begin
      duration_nxt = duration_in;
    end
    flow_ok = flow_r || simulated;
    period = (interval_s > duration_r) ? {1'b0, interval_s} : {1'b0, duration_r};
    acc_sum = log_acc_r + period;
    valid_x = simulated || !low_flow_off || (pcnt_r >= LOW_PARTICLE_MIN);
    if (particle_gt4 && pcnt_r != {PCNT_W{1'b1}})
    begin
      pcnt_nxt = pcnt_r + PCNT_W'(1);
    end
    unique case (state_r)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          state_nxt = ST_TESTING;
          elapsed_nxt = '0;
          pcnt_nxt = '0;
          ignore_left_nxt = ignore_count;
          clean_run_nxt = '0;
          log_acc_nxt = '0;
          log_due_nxt = 1'b1;
          alarm_nxt = 1'b0;
        end
      end
      ST_TESTING:
      begin
        if (stop_cmd)
        begin
          state_nxt = ST_IDLE;
        end
        else if (start_cmd)
        begin
          elapsed_nxt = '0;
          pcnt_nxt = '0;
        end
        else if (tick_r && flow_ok)
        begin
          elapsed_nxt = elapsed_r + SEC_W'(1);
          if (elapsed_r + SEC_W'(1) >= duration_r)
          begin
            finish_ev = 1'b1;
          end
        end
      end
      ST_WAITING:
      begin
        if (stop_cmd)
        begin
          state_nxt = ST_IDLE;
        end
        else if (start_cmd || (tick_r && elapsed_r + SEC_W'(1) >= interval_s))
        begin
          state_nxt = ST_TESTING;
          elapsed_nxt = '0;
          pcnt_nxt = '0;
        end
        else if (tick_r)
        begin
          elapsed_nxt = elapsed_r + SEC_W'(1);
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (finish_ev)
    begin
      done_nxt = 1'b1;
      number_nxt = number_r + NUM_W'(1);
      fmt_nxt = format;
      codes_nxt = result_code;
      valid_nxt = valid_x;
      fault_nxt = !simulated && (pcnt_r < LOW_PARTICLE_MIN);
      clean_nxt = valid_x && (&ch_met);
      if (valid_x && (&ch_met))
      begin
        if (clean_run_r != {CNT_W{1'b1}})
        begin
          clean_run_nxt = clean_run_r + CNT_W'(1);
        end
      end
      else
      begin
        clean_run_nxt = '0;
      end
      halt_x = stop_when_clean && valid_x && (&ch_met) &&
               (!confirm_en || (clean_run_r + CNT_W'(1) >= confirm_count));
      if (continuous_test && continuous_log)
      begin
        want_log = log_due_r;
      end
      else
      begin
        want_log = !continuous_test || halt_x;
      end
      if (ignore_left_r != '0)
      begin
        ignore_left_nxt = ignore_left_r - CNT_W'(1);
      end
      else
      begin
        log_wr_nxt = want_log;
      end
      if (halt_x)
      begin
        alarm_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      else if (!continuous_test)
      begin
        state_nxt = ST_IDLE;
      end
      else
      begin
        if (log_interval_s == '0)
        begin
          log_due_nxt = 1'b1;
        end
        else if (acc_sum >= {1'b0, log_interval_s})
        begin
          log_due_nxt = 1'b1;
          log_acc_nxt = acc_sum - {1'b0, log_interval_s};
        end
        else
        begin
          log_due_nxt = 1'b0;
          log_acc_nxt = acc_sum;
        end
        if (interval_s > duration_r)
        begin
          state_nxt = ST_WAITING;
        end
        else
        begin
          state_nxt = ST_TESTING;
          elapsed_nxt = '0;
          pcnt_nxt = '0;
        end
      end
    end
    testing_nxt = (state_nxt == ST_TESTING);
    waiting_nxt = (state_nxt == ST_WAITING);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      duration_r <= DURATION_DEF_S;
      elapsed_r <= '0;
      pcnt_r <= '0;
      ignore_left_r <= '0;
      clean_run_r <= '0;
      log_acc_r <= '0;
      log_due_r <= 1'b0;
      number_r <= TEST_NUMBER_INIT;
      fmt_r <= FMT_ISO;
      codes_r <= '0;
      valid_r <= 1'b0;
      clean_r <= 1'b0;
      fault_r <= 1'b0;
      alarm_r <= 1'b0;
      done_r <= 1'b0;
      log_wr_r <= 1'b0;
      testing_r <= 1'b0;
      waiting_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      duration_r <= duration_nxt;
      elapsed_r <= elapsed_nxt;
      pcnt_r <= pcnt_nxt;
      ignore_left_r <= ignore_left_nxt;
      clean_run_r <= clean_run_nxt;
      log_acc_r <= log_acc_nxt;
      log_due_r <= log_due_nxt;
      number_r <= number_nxt;
      fmt_r <= fmt_nxt;
      codes_r <= codes_nxt;
      valid_r <= valid_nxt;
      clean_r <= clean_nxt;
      fault_r <= fault_nxt;
      alarm_r <= alarm_nxt;
      done_r <= done_nxt;
      log_wr_r <= log_wr_nxt;
      testing_r <= testing_nxt;
      waiting_r <= waiting_nxt;
    end
  end

  // configuration check and log pointers
  logic cfg_err_r, cfg_err_nxt;
  logic [AW-1:0] head_r, head_nxt;
  logic [AW:0] count_r, count_nxt;
  always_comb
  begin
    if (!continuous_log)
    begin
      cfg_err_nxt = 1'b0;
    end
    else if (interval_s == '0)
    begin
      cfg_err_nxt = (log_interval_s != '0);
    end
    else
    begin
      cfg_err_nxt = ((log_interval_s % interval_s) != '0);
    end
    head_nxt = head_r;
    count_nxt = count_r;
    if (log_wr_r)
    begin
      head_nxt = (head_r == AW'(DEPTH - 1)) ? '0 : head_r + AW'(1);
      if (count_r != (AW + 1)'(DEPTH))
      begin
        count_nxt = count_r + (AW + 1)'(1);
      end
    end
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cfg_err_r <= 1'b0;
      head_r <= '0;
      count_r <= '0;
    end
    else
    begin
      cfg_err_r <= cfg_err_nxt;
      head_r <= head_nxt;
      count_r <= count_nxt;
    end
  end

  log_memory #(.WIDTH(REC_W), .DEPTH(DEPTH), .AW(AW)) u_log (
    .clock(clock),
    .wr_en(log_wr_r),
    .wr_addr(head_r),
    .wr_data({number_r - NUM_W'(1), codes_r, fmt_r, valid_r}),
    .rd_addr(log_rd_addr),
    .rd_data(log_rd_data)
  );

  assign testing = testing_r;
  assign waiting = waiting_r;
  assign test_done = done_r;
  assign test_valid = valid_r;
  assign flow_shown = valid_r;
  assign low_count_fault = fault_r;
  assign result_clean = clean_r;
  assign clean_alarm = alarm_r;
  assign cfg_error = cfg_err_r;
  assign test_number = number_r;
  assign result_format = fmt_r;
  assign log_count = count_r;
  assign log_head = head_r;

  chk_duration_end: assert property (@(posedge clock) disable iff (reset)
    (state_r == ST_TESTING && tick_r && flow_ok && !stop_cmd && !start_cmd && elapsed_r + SEC_W'(1) >= duration_r)
    |=> done_r) else $error("test did not end at its duration");
  chk_low_fault: assert property (@(posedge clock) disable iff (reset)
    (finish_ev && !simulated && pcnt_r < LOW_PARTICLE_MIN) |=> fault_r && done_r) else $error("low count fault missing");
  chk_low_valid: assert property (@(posedge clock) disable iff (reset)
    (finish_ev && low_flow_off && !simulated && pcnt_r < LOW_PARTICLE_MIN) |=> !valid_r) else $error("low count marked valid");
  chk_stop_abandon: assert property (@(posedge clock) disable iff (reset)
    (state_r != ST_IDLE && stop_cmd) |=> (state_r == ST_IDLE && !done_r && !testing_r)) else $error("stop not honoured");
  chk_back_to_back: assert property (@(posedge clock) disable iff (reset)
    (finish_ev && !halt_x && continuous_test && interval_s <= duration_r) |=> (testing_r && elapsed_r == '0))
    else $error("no immediate restart");
  chk_number_step: assert property (@(posedge clock) disable iff (reset)
    finish_ev |=> number_r == $past(number_r) + NUM_W'(1)) else $error("test number did not step");
  chk_log_wrap: assert property (@(posedge clock) disable iff (reset)
    (log_wr_r && head_r == AW'(DEPTH - 1)) |=> (head_r == '0 && count_r == (AW + 1)'(DEPTH))) else $error("log wrap wrong");
  chk_clean_halt: assert property (@(posedge clock) disable iff (reset)
    (finish_ev && halt_x) |=> (alarm_r && state_r == ST_IDLE) ##1 !testing_r) else $error("clean halt missing");
  chk_cfg_flag: assert property (@(posedge clock) disable iff (reset)
    (continuous_log && interval_s != '0 && (log_interval_s % interval_s) != '0) |=> cfg_err_r) else $error("cfg error missed");
endmodule : test_scheduling_sequencer

// >>> rtl/test_seq_pkg.sv
package test_seq_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int SEC_W = 20;
  localparam int CODE_W = 5;
  localparam int NUM_CH = 8;
  localparam int NUM_W = 16;
  localparam int PCNT_W = 16;
  localparam int CNT_W = 8;
  localparam logic [SEC_W-1:0] DURATION_DEF_S = SEC_W'(120);
  localparam logic [PCNT_W-1:0] LOW_PARTICLE_MIN = PCNT_W'(20);
  localparam logic [NUM_W-1:0] TEST_NUMBER_INIT = 16'h0001;
  localparam int LOG_DEPTH = 4000;
  localparam int REC_W = NUM_W + NUM_CH * CODE_W + 2 + 1;
  typedef enum logic [1:0] {FMT_ISO, FMT_NAS, FMT_AS_T2, FMT_AS_T1} format_e;
  // channels that carry a target in each format
  localparam logic [NUM_CH-1:0] FMT_MASK [4] = '{8'hFF, 8'h1F, 8'h3F, 8'h1F};
endpackage : test_seq_pkg

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) check_val(nm, 64'(e), 64'(g))
module tb_top;
  import test_seq_pkg::*;
  localparam int T = 8;
  localparam int D = 6;
  localparam int AW = 3;
  logic clock = 0;
  logic reset = 1;
  logic start_cmd = 0, stop_cmd = 0, cfg_defaults = 0, duration_wr = 0;
  logic [SEC_W-1:0] duration_in = '0, interval_s = '0, log_interval_s = '0;
  logic continuous_test = 0, continuous_log = 0, simulated = 0, low_flow_off = 0;
  logic stop_when_clean = 0, confirm_en = 0, flow_pin = 0, particle_gt4 = 0;
  logic [CNT_W-1:0] confirm_count = '0, ignore_count = '0;
  format_e format = FMT_ISO;
  logic [NUM_CH-1:0] target_set = '0;
  logic [NUM_CH-1:0][CODE_W-1:0] target_code = '0, result_code = '0;
  logic [AW-1:0] log_rd_addr = '0;
  logic testing, waiting, test_done, test_valid, flow_shown, low_count_fault;
  logic result_clean, clean_alarm, cfg_error;
  logic [NUM_W-1:0] test_number;
  format_e result_format;
  logic [AW:0] log_count;
  logic [AW-1:0] log_head;
  logic [REC_W-1:0] log_rd_data;
  // bench model state
  int fails = 0, checks_done = 0, cycles = 0;
  int m_num = 1, pcnt = 0, k = 0, acc = 0, run = 0, ign = 0, mcount = 0, mhead = 0, dur = 120;
  int seed;
  logic [REC_W-1:0] mlog [D];

  test_scheduling_sequencer #(.TICK_CYCLES(T), .DEPTH(D), .AW(AW)) DUT (
    .clock(clock), .reset(reset), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .cfg_defaults(cfg_defaults), .duration_wr(duration_wr), .duration_in(duration_in),
    .interval_s(interval_s), .log_interval_s(log_interval_s), .continuous_test(continuous_test),
    .continuous_log(continuous_log), .simulated(simulated), .low_flow_off(low_flow_off),
    .stop_when_clean(stop_when_clean), .confirm_en(confirm_en), .confirm_count(confirm_count),
    .ignore_count(ignore_count), .format(format), .target_set(target_set), .target_code(target_code),
    .flow_pin(flow_pin), .particle_gt4(particle_gt4), .result_code(result_code),
    .log_rd_addr(log_rd_addr), .testing(testing), .waiting(waiting), .test_done(test_done),
    .test_valid(test_valid), .flow_shown(flow_shown), .low_count_fault(low_count_fault),
    .result_clean(result_clean), .clean_alarm(clean_alarm), .cfg_error(cfg_error),
    .test_number(test_number), .result_format(result_format), .log_count(log_count),
    .log_head(log_head), .log_rd_data(log_rd_data)
  );

  initial
  begin
    forever #4 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      $display("unexpected run length expected below 30000 seen 30000");
      complete_run();
    end
  end

  task automatic check_val(string nm, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // expected flags and log selection at each completion
  task automatic mon_done();
    logic v;
    logic c;
    logic h;
    logic lg;
    v = !low_flow_off || pcnt >= 20;
    c = v;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (FMT_MASK[format][i] && target_set[i] && result_code[i] > target_code[i])
      begin
        c = 0;
      end
    end
    h = stop_when_clean && c && (run + 1 >= (confirm_en ? int'(confirm_count) : 1));
    run = c ? run + 1 : 0;
    if (k > 0)
    begin
      acc += (int'(interval_s) > dur) ? int'(interval_s) : dur;
    end
    lg = !continuous_test || (continuous_log ? (k == 0 || log_interval_s == 0 || acc >= log_interval_s) : h);
    if (lg && continuous_log)
    begin
      acc = 0;
    end
    if (ign > 0)
    begin
      ign--;
      lg = 0;
    end
    `CHK("test_number", m_num + 1, test_number);
    `CHK("test_valid", v, test_valid);
    `CHK("flow_shown", v, flow_shown);
    `CHK("low_count_fault", pcnt < 20 && !simulated, low_count_fault);
    `CHK("result_clean", c, result_clean);
    `CHK("result_format", format, result_format);
    if (lg)
    begin
      mlog[mhead] = {NUM_W'(m_num), result_code, format, v};
      mhead = (mhead + 1) % D;
      mcount++;
    end
    m_num++;
    k++;
  endtask : mon_done

  always @(negedge clock)
  begin
    if (!reset && test_done === 1'b1)
    begin
      mon_done();
    end
  end

  task automatic start_seq();
    k = 0;
    acc = 0;
    run = 0;
    pcnt = 0;
    ign = ignore_count;
    start_cmd = 1;
    cyc(1);
    start_cmd = 0;
    cyc(1);
  endtask : start_seq

  task automatic stop_seq();
    stop_cmd = 1;
    cyc(1);
    stop_cmd = 0;
    cyc(1);
  endtask : stop_seq

  task automatic set_dur(int d);
    duration_in = SEC_W'(d);
    duration_wr = 1;
    cyc(1);
    duration_wr = 0;
    dur = d;
  endtask : set_dur

  // returns one cycle after test_done so the monitor sees settled inputs
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (test_done !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      fails++;
      $display("unexpected test_done expected 1 seen 0");
    end
    cyc(1);
  endtask : wait_done

  task automatic wait_rise(output int n);
    n = 0;
    while (testing === 1'b1 && n < 500)
    begin
      cyc(1);
      n++;
    end
    while (testing !== 1'b1 && n < 500)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_rise

  task automatic check_log();
    int c;
    cyc(4);
    c = mcount < D ? mcount : D;
    `CHK("log_count", c, log_count);
    `CHK("log_head", mhead, log_head);
    for (int i = 0; i < c; i++)
    begin
      log_rd_addr = AW'(i);
      cyc(1);
      `CHK("log_rd_data", mlog[i], log_rd_data);
    end
  endtask : check_log

  initial
  begin
    int n;
    logic [5:0] pat;
    seed = 32'h93377E4D;
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset = 0;
    `CHK("test_number", 1, test_number);
    `CHK("testing", 0, testing);
    set_dur(3);
    simulated = 1;
    for (int i = 0; i < 4; i++)
    begin
      format = format_e'(i);
      target_set = 8'($random(seed));
      target_code = 40'({$random(seed), $random(seed)});
      result_code = 40'({$random(seed), $random(seed)});
      start_seq();
      wait_done(n);
      `CHK("duration", 1, n inside {[2 * T:3 * T + 1]});
    end
    simulated = 0;
    flow_pin = 1;
    set_dur(8);
    for (int i = 0; i < 3; i++)
    begin
      low_flow_off = i < 2;
      start_seq();
      repeat (i == 0 ? 19 : (i == 1 ? 20 : 10))
      begin
        particle_gt4 = 1;
        pcnt++;
        cyc(1);
        particle_gt4 = 0;
        cyc(1);
      end
      wait_done(n);
    end
    simulated = 1;
    low_flow_off = 0;
    cfg_defaults = 1;
    duration_wr = 1;
    cyc(1);
    cfg_defaults = 0;
    duration_wr = 0;
    dur = 120;
    start_seq();
    wait_done(n);
    `CHK("default duration", 1, n inside {[119 * T:120 * T + 1]});
    check_log();
    set_dur(3);
    start_seq();
    cyc(10);
    start_cmd = 1;
    cyc(1);
    start_cmd = 0;
    wait_done(n);
    `CHK("restart", 1, n inside {[2 * T - 1:3 * T + 1]});
    start_seq();
    cyc(5);
    stop_seq();
    `CHK("testing", 0, testing);
    cyc(4 * T);
    `CHK("test_number", m_num, test_number);
    continuous_log = 1;
    interval_s = 2;
    log_interval_s = 3;
    cyc(2);
    `CHK("cfg_error", 1, cfg_error);
    log_interval_s = 4;
    cyc(2);
    `CHK("cfg_error", 0, cfg_error);
    continuous_test = 1;
    set_dur(2);
    interval_s = 5;
    log_interval_s = 10;
    start_seq();
    wait_done(n);
    wait_rise(n);
    cyc(2 * T + 4);
    `CHK("waiting", 1, waiting);
    wait_rise(n);
    `CHK("interval", 1, (n + 2 * T + 4) inside {[5 * T - 1:5 * T + 1]});
    stop_seq();
    interval_s = 0;
    log_interval_s = 0;
    ignore_count = 2;
    start_seq();
    repeat (4)
    begin
      wait_done(n);
      `CHK("testing", 1, testing);
    end
    stop_seq();
    continuous_log = 0;
    ignore_count = 0;
    stop_when_clean = 1;
    confirm_en = 1;
    confirm_count = 2;
    set_dur(1);
    target_set = 8'hFF;
    target_code = {NUM_CH{5'h10}};
    // bit i set: test i comes out clean
    pat = 6'b011010;
    result_code = {NUM_CH{5'h1F}};
    start_seq();
    for (int i = 0; i < 5; i++)
    begin
      wait_done(n);
      result_code = pat[i + 1] ? {NUM_CH{5'h00}} : {NUM_CH{5'h1F}};
    end
    cyc(2);
    `CHK("clean_alarm", 1, clean_alarm);
    `CHK("testing", 0, testing);
    check_log();
    complete_run();
  end
endmodule : tb_top
